// >>> src/t1tb_defs.svh
`ifndef T1TB_DEFS_SVH
`define T1TB_DEFS_SVH
// Register byte offsets on the bus.
`define T1TB_OFS_CTRL 6'h00
`define T1TB_OFS_CNT_LO 6'h04
`define T1TB_OFS_CNT_HI 6'h08
`define T1TB_OFS_MAT_LO 6'h0c
`define T1TB_OFS_MAT_HI 6'h10
`define T1TB_OFS_CCP 6'h14
`define T1TB_OFS_FLAG 6'h18
`define T1TB_OFS_IEN 6'h1c
`define T1TB_OFS_CORE 6'h20
`define T1TB_OFS_STAT 6'h24
// Control register fields.
`define T1TB_CTL_ON 0
`define T1TB_CTL_SRC 2:1
`define T1TB_CTL_OSC 3
`define T1TB_CTL_UNSYNC 4
`define T1TB_CTL_MASK 8'h1f
// Capture/compare control fields.
`define T1TB_CCP_MODE 1:0
`define T1TB_CCP_EDGE 2
// Flag and enable bits, same layout.
`define T1TB_FLG_OVF 0
`define T1TB_FLG_CCP 1
// Core interrupt control bits.
`define T1TB_CORE_PERIPH 6
`define T1TB_CORE_GLOBAL 7
// Reset values and counter limits.
`define T1TB_RST_BYTE 8'h00
`define T1TB_CNT_MAX 16'hffff
`define T1TB_CNT_ZERO 16'h0000
// System clock divider for the slow count source.
`define T1TB_SYS_DIV 4
`endif

// >>> src/t1tb_pkg.sv
package t1tb_pkg;
    // Count source choices.
    typedef enum logic [1:0] {T1TB_SRC_DIV, T1TB_SRC_SYS, T1TB_SRC_PIN, T1TB_SRC_OSC} t1tb_src_e;
    // Capture/compare modes.
    typedef enum logic [1:0] {T1TB_CCP_OFF, T1TB_CCP_CAPTURE, T1TB_CCP_COMPARE,
        T1TB_CCP_SPECIAL} t1tb_ccp_e;
    // State of the top module.
    typedef struct packed {
        logic waitReq;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [15:0] count;
        logic [15:0] match;
        logic [2:0] ccpCtrl;
        logic [1:0] flags;
        logic [1:0] enables;
        logic [1:0] core;
        logic irq;
        logic wake;
        logic oscOn;
    } t1tb_core_s;
    // State of the tick generator.
    typedef struct packed {
        logic [1:0] div;
        logic pinPrev;
        logic tick;
    } t1tb_tick_s;
    // State of the capture/compare unit.
    typedef struct packed {
        logic pinPrev;
        logic eqPrev;
        logic cap;
        logic cmp;
    } t1tb_ccp_s;
endpackage

// >>> src/t1tb_link_if.sv
`timescale 1ns/1ps
// Signals shared by the core, the tick generator and the capture unit.
interface t1tb_link_if;
    logic tick;
    t1tb_pkg::t1tb_src_e src;
    logic [15:0] count;
    logic [15:0] match;
    t1tb_pkg::t1tb_ccp_e mode;
    logic capEdge;
    logic captureEvt;
    logic compareEvt;
    modport core (output src, count, match, mode, capEdge, input tick, captureEvt, compareEvt);
    modport src_side (input src, output tick);
    modport ccp (input count, match, mode, capEdge, output captureEvt, compareEvt);
endinterface

// >>> src/t1tb_tick_gen.sv
`timescale 1ns/1ps
`include "t1tb_defs.svh"
// Turns the selected count source into one-cycle count enables.
module t1tb_tick_gen (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic extClkPin,
    input wire logic oscEnable,
    t1tb_link_if.src_side lnk
);
    t1tb_pkg::t1tb_tick_s r;
    t1tb_pkg::t1tb_tick_s n;
    logic pinRise;
    // Divider, pin edge detect and source choice.
    always_comb
    begin
        n = r;
        pinRise = extClkPin && !r.pinPrev;
        n.pinPrev = extClkPin;
        n.div = r.div + 2'd1;
        case (lnk.src)
            t1tb_pkg::T1TB_SRC_DIV: n.tick = (r.div == 2'(`T1TB_SYS_DIV - 1));
            t1tb_pkg::T1TB_SRC_SYS: n.tick = 1'b1;
            t1tb_pkg::T1TB_SRC_PIN: n.tick = pinRise;
            t1tb_pkg::T1TB_SRC_OSC: n.tick = pinRise && oscEnable;
            default: n.tick = 1'b0;
        endcase
    end
    // State register.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            r <= '0;
        else
            r <= n;
    end
    assign lnk.tick = r.tick;
endmodule

// >>> src/t1tb_ccp.sv
`timescale 1ns/1ps
// Capture edge detect and compare match detect on the counter.
module t1tb_ccp (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ccpPin,
    t1tb_link_if.ccp lnk
);
    t1tb_pkg::t1tb_ccp_s r;
    t1tb_pkg::t1tb_ccp_s n;
    logic pinEdge;
    logic equal;
    // Events are one-cycle pulses.
    always_comb
    begin
        n = r;
        pinEdge = lnk.capEdge ? (ccpPin && !r.pinPrev) : (!ccpPin && r.pinPrev);
        equal = (lnk.count == lnk.match);
        n.pinPrev = ccpPin;
        n.eqPrev = equal;
        n.cap = (lnk.mode == t1tb_pkg::T1TB_CCP_CAPTURE) && pinEdge;
        // A match fires once, when equality begins.
        n.cmp = ((lnk.mode == t1tb_pkg::T1TB_CCP_COMPARE) ||
            (lnk.mode == t1tb_pkg::T1TB_CCP_SPECIAL)) && equal && !r.eqPrev;
    end
    // State register.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            r <= '0;
        else
            r <= n;
    end
    assign lnk.captureEvt = r.cap;
    assign lnk.compareEvt = r.cmp;
endmodule

// >>> src/t1tb_timer.sv
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "t1tb_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Count up to FFFFh, then wrap to 0000h.
// - Wrap sets the overflow flag.
// - Overflow interrupt needs on, enable, peripheral, global.
// - Flag stays set until software clears it.
// - In sleep, count only as asynchronous counter.
// - Asynchronous mode counts external crystal or clock.
// - Overflow in sleep wakes the processor when enable and peripheral are set.
// - With global enable set, wake also interrupts.
// - Dedicated oscillator runs in sleep regardless.
// - Capture/compare uses this counter as time base.
// - Capture event copies count into match pair.
// - Match of pair and count raises an event.
// - Special event clears count, no overflow flag.
// - Counter write beats a coincident special event.
module t1tb_timer #(
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [AW-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic extClkPin,
    input wire logic ccpPin,
    input wire logic sleepIn,
    output logic irq,
    output logic wakeReq,
    output logic oscRun
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    // Registered state and its next value.
    t1tb_pkg::t1tb_core_s state_reg;
    t1tb_pkg::t1tb_core_s state_next;

    // Shared signals with the two helper modules.
    t1tb_link_if lnk ();

    // A write that completes in this cycle, low byte enabled.
    logic busWr;

    // A request that is being accepted into the answer register.
    logic busReq;

    // Counting is allowed in the present power state.
    logic countOn;

    // The counter wraps in this cycle.
    logic overflow;

    // The compare unit asks for a counter clear.
    logic special;

    // Software writes a counter byte in this cycle.
    logic cntWrite;

    // Write-one-to-clear mask for the flag register.
    logic [1:0] clearMask;

    // Events that set flags in this cycle.
    logic [1:0] setMask;

    // Source is one of the external ones.
    logic extSource;

    ////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Places a byte in the low lane of a bus word.
    function automatic logic [31:0] lowByte(input logic [7:0] b);
        lowByte = {24'h000000, b};
    endfunction

    // Builds the read word for an address.
    function automatic logic [31:0] readWord(
        input t1tb_pkg::t1tb_core_s s,
        input logic [AW-1:0] a,
        input logic slp
    );
        case (a)
            `T1TB_OFS_CTRL: readWord = lowByte(s.ctrl);
            `T1TB_OFS_CNT_LO: readWord = lowByte(s.count[7:0]);
            `T1TB_OFS_CNT_HI: readWord = lowByte(s.count[15:8]);
            `T1TB_OFS_MAT_LO: readWord = lowByte(s.match[7:0]);
            `T1TB_OFS_MAT_HI: readWord = lowByte(s.match[15:8]);
            `T1TB_OFS_CCP: readWord = lowByte({5'h00, s.ccpCtrl});
            `T1TB_OFS_FLAG: readWord = lowByte({6'h00, s.flags});
            `T1TB_OFS_IEN: readWord = lowByte({6'h00, s.enables});
            `T1TB_OFS_CORE: readWord = lowByte({s.core, 6'h00});
            `T1TB_OFS_STAT: readWord = lowByte({6'h00, slp, s.oscOn});
            // Unmapped addresses read as zero.
            default: readWord = 32'h00000000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Helper modules.

    // The shared signals are driven from the state register.
    assign lnk.src = t1tb_pkg::t1tb_src_e'(state_reg.ctrl[`T1TB_CTL_SRC]);
    assign lnk.count = state_reg.count;
    assign lnk.match = state_reg.match;
    assign lnk.mode = t1tb_pkg::t1tb_ccp_e'(state_reg.ccpCtrl[`T1TB_CCP_MODE]);
    assign lnk.capEdge = state_reg.ccpCtrl[`T1TB_CCP_EDGE];

    // Produces count enables from the chosen source.
    t1tb_tick_gen u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .extClkPin(extClkPin),
        .oscEnable(state_reg.ctrl[`T1TB_CTL_OSC]),
        .lnk(lnk.src_side)
    );

    // Detects capture edges and compare matches.
    t1tb_ccp u_ccp (
        .clk(clk),
        .sys_rst(sys_rst),
        .ccpPin(ccpPin),
        .lnk(lnk.ccp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // All register, counter and interrupt behaviour is computed here.
    always_comb
    begin
        state_next = state_reg;

        // Bus handshake: one wait cycle, then completion.
        busReq = (read || write) && state_reg.waitReq;
        busWr = write && !state_reg.waitReq && byteenable[0];
        if (busReq)
        begin
            // Answer is ready at the next edge.
            state_next.waitReq = 1'b0;
            // Read data stand until the next read answer; a write leaves them alone.
            if (read)
            begin
                state_next.rdata = readWord(state_reg, address, sleepIn);
            end
        end
        else
        begin
            // Idle or just completed: stall the next request.
            state_next.waitReq = 1'b1;
        end

        // Plain register writes.
        clearMask = 2'b00;
        if (busWr)
        begin
            case (address)
                `T1TB_OFS_CTRL: state_next.ctrl = writedata[7:0] & `T1TB_CTL_MASK;
                `T1TB_OFS_MAT_LO: state_next.match[7:0] = writedata[7:0];
                `T1TB_OFS_MAT_HI: state_next.match[15:8] = writedata[7:0];
                `T1TB_OFS_CCP: state_next.ccpCtrl = writedata[2:0];
                `T1TB_OFS_FLAG: clearMask = writedata[1:0];
                `T1TB_OFS_IEN: state_next.enables = writedata[1:0];
                `T1TB_OFS_CORE: state_next.core = writedata[7:6];
                // Other addresses, counters included, are handled below.
                default: clearMask = 2'b00;
            endcase
        end

        // Sleep gating of the count enable.
        extSource = (lnk.src == t1tb_pkg::T1TB_SRC_PIN) ||
            (lnk.src == t1tb_pkg::T1TB_SRC_OSC);
        countOn = state_reg.ctrl[`T1TB_CTL_ON] &&
            (!sleepIn || (extSource && state_reg.ctrl[`T1TB_CTL_UNSYNC]));

        // Counting and wrap detection.
        overflow = 1'b0;
        if (countOn && lnk.tick)
        begin
            // The sum wraps naturally from the maximum to zero.
            state_next.count = state_reg.count + 16'h0001;
            overflow = (state_reg.count == `T1TB_CNT_MAX);
        end

        // Special event clears the counter and is no overflow.
        special = lnk.compareEvt && (lnk.mode == t1tb_pkg::T1TB_CCP_SPECIAL);
        if (special)
        begin
            state_next.count = `T1TB_CNT_ZERO;
            overflow = 1'b0;
        end

        // Software counter writes come last, so they beat the clear.
        cntWrite = busWr && ((address == `T1TB_OFS_CNT_LO) ||
            (address == `T1TB_OFS_CNT_HI));
        if (busWr && (address == `T1TB_OFS_CNT_LO))
        begin
            state_next.count[7:0] = writedata[7:0];
        end
        if (busWr && (address == `T1TB_OFS_CNT_HI))
        begin
            state_next.count[15:8] = writedata[7:0];
        end
        if (cntWrite)
        begin
            // A written counter does not also wrap in this cycle.
            overflow = 1'b0;
        end

        // Capture copies the running count into the match pair.
        if (lnk.captureEvt)
        begin
            state_next.match = state_reg.count;
        end

        // Sticky flags: a new event wins over a clear.
        setMask = 2'b00;
        setMask[`T1TB_FLG_OVF] = overflow;
        setMask[`T1TB_FLG_CCP] = lnk.captureEvt || lnk.compareEvt;
        state_next.flags = (state_reg.flags & ~clearMask) | setMask;

        // Interrupt line: all four gates for the overflow source.
        state_next.irq = (((state_next.flags[`T1TB_FLG_OVF] &&
            state_next.enables[`T1TB_FLG_OVF] && state_next.ctrl[`T1TB_CTL_ON]) ||
            (state_next.flags[`T1TB_FLG_CCP] && state_next.enables[`T1TB_FLG_CCP])) &&
            state_next.core[0] && state_next.core[1]);

        // Wake pulse: overflow in sleep with its enables, global not needed.
        state_next.wake = sleepIn && overflow &&
            state_reg.enables[`T1TB_FLG_OVF] && state_reg.core[0];

        // The dedicated oscillator follows its enable in any power state.
        state_next.oscOn = state_next.ctrl[`T1TB_CTL_OSC];
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    // Reset leaves the timer stopped, flags clear and the bus stalled.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= '0;
            state_reg.waitReq <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Each output is a field of the state register.
    assign readdata = state_reg.rdata;
    assign waitrequest = state_reg.waitReq;
    assign irq = state_reg.irq;
    assign wakeReq = state_reg.wake;
    assign oscRun = state_reg.oscOn;

endmodule

// >>> tb/t1tb_timer_assertions.sv
`timescale 1ns/1ps
`include "t1tb_defs.svh"
// Watches the bus handshake and the timer outputs at the top ports.
module t1tb_timer_chk #(
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [AW-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic extClkPin,
    input wire logic ccpPin,
    input wire logic sleepIn,
    input wire logic irq,
    input wire logic wakeReq,
    input wire logic oscRun
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // A request seen while the slave is still busy.
    sequence s_taken;
        (read || write) && waitrequest;
    endsequence
    // One cycle of answer, then busy again.
    sequence s_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    // A completed write of the low byte.
    sequence s_wrDone;
        write && !waitrequest && byteenable[0];
    endsequence
    a_bus_answer: assert property (s_taken |=> s_answer) else $error("bad answer timing");
    a_read_unmapped: assert property (read && !waitrequest && address > `T1TB_OFS_STAT
        |-> readdata == 32'h0) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!$stable(readdata) |-> read)
        else $error("read data moved without a read");
    a_status_view: assert property (read && !waitrequest && address == `T1TB_OFS_STAT
        |-> readdata[1:0] == {$past(sleepIn), oscRun}) else $error("status wrong");
    a_osc_follows: assert property (s_wrDone and address == `T1TB_OFS_CTRL
        |=> oscRun == $past(writedata[3])) else $error("osc enable not applied");
    a_osc_steady: assert property (!(write && address == `T1TB_OFS_CTRL) |=> $stable(oscRun))
        else $error("osc run changed by itself");
    a_irq_global: assert property (s_wrDone and address == `T1TB_OFS_CORE && !writedata[7]
        |-> ##2 !irq) else $error("irq without global enable");
    a_irq_mask: assert property (s_wrDone and address == `T1TB_OFS_IEN && writedata[1:0] == 2'b00
        |-> ##2 !irq) else $error("irq while masked");
    a_wake_asleep: assert property (wakeReq |-> $past(sleepIn))
        else $error("wake while awake");
    a_wake_pulse: assert property (wakeReq |=> !wakeReq) else $error("wake too long");
endmodule
bind t1tb_timer t1tb_timer_chk #(.AW(AW)) chk_u (.clk(clk), .sys_rst(sys_rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .extClkPin(extClkPin), .ccpPin(ccpPin),
    .sleepIn(sleepIn), .irq(irq), .wakeReq(wakeReq), .oscRun(oscRun));

// >>> tb/t1tb_far_end.sv
`timescale 1ns/1ps
// Model of the external clock source and of the capture signal source.
module t1tb_far_end (
    input wire logic clk,
    input wire logic runExt,
    input wire logic [3:0] halfPeriod,
    input wire logic capPulse,
    output logic extClkPin,
    output logic ccpPin
);
    logic [3:0] phase; // Cycles spent in the current half period.
    // The external clock runs only while enabled and stands low otherwise.
    always @(posedge clk)
    begin
        if (!runExt)
        begin
            phase <= 4'h0;
            extClkPin <= 1'b0;
        end
        else if (phase >= halfPeriod)
        begin
            phase <= 4'h0;
            extClkPin <= !extClkPin;
        end
        else
            phase <= phase + 4'h1;
    end
    // The capture source gives a clean registered level.
    always @(posedge clk)
        ccpPin <= capPulse;
endmodule

// >>> tb/timer1_overflow_sleep_timebase_test.sv
`timescale 1ns/1ps
`include "t1tb_defs.svh"
// Drives the timer through its bus and pins and checks what it does.
module timer1_overflow_sleep_timebase_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic waitrequest, extClkPin, ccpPin, irq, wakeReq, oscRun;
    logic sleepIn = 1'b0;
    logic runExt = 1'b0;
    logic capPulse = 1'b0;
    logic [3:0] halfPeriod = 4'h1;
    logic [7:0] rd;
    logic [31:0] wd;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'h9e4dd6c2;
    int i;
    int k;
    t1tb_timer #(.AW(6)) dut_u (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .extClkPin(extClkPin), .ccpPin(ccpPin), .sleepIn(sleepIn),
        .irq(irq), .wakeReq(wakeReq), .oscRun(oscRun));
    t1tb_far_end far_u (.clk(clk), .runExt(runExt), .halfPeriod(halfPeriod),
        .capPulse(capPulse), .extClkPin(extClkPin), .ccpPin(ccpPin));
    // The clock toggles every half period.
    always #2.5 clk = !clk;
    // A hang counts as a mismatch and ends the run.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            fails = fails + 1;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Ends the run with the counts and the verdict.
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Compares a byte result.
    task automatic checkByte(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // Compares a single bit result.
    task automatic checkBit(input string n, input logic e, input logic g);
        checkByte(n, {7'h00, e}, {7'h00, g});
    endtask
    // One bus write, held until the slave answers.
    task automatic busWrite(input logic [5:0] a, input logic [7:0] d, input logic be = 1'b1);
        @(posedge clk);
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= {3'b000, be};
        write <= 1'b1;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        write <= 1'b0;
    endtask
    // One bus read; data is taken at the answering edge.
    task automatic busRead(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        d = readdata[7:0];
        read <= 1'b0;
    endtask
    // Reads the flag register until the chosen bit is set, a bounded number of times.
    task automatic pollFlag(input int b);
        rd = 8'h00;
        for (k = 0; k < 30 && rd[b] !== 1'b1; k++) busRead(`T1TB_OFS_FLAG, rd);
    endtask
    // Builds a control byte from its fields.
    function automatic logic [7:0] expCtrl(logic on, t1tb_pkg::t1tb_src_e src, logic osc,
        logic unsync);
        return {3'b000, unsync, osc, src, on};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence of scenarios.
    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        // Every register reads zero after reset, and so does one unmapped place.
        for (i = 0; i <= 10; i++)
        begin
            busRead(6'(i * 4), rd);
            checkByte("reset value", 8'h00, rd);
        end
        // Random bytes into count and match; a write without the byte enable is dropped.
        for (i = 0; i < 8; i++)
        begin
            wd = $random(seed);
            busWrite(`T1TB_OFS_CNT_LO + 6'(4 * (i % 4)), wd[7:0]);
            busWrite(`T1TB_OFS_CNT_LO + 6'(4 * (i % 4)), wd[15:8], 1'b0);
            busRead(`T1TB_OFS_CNT_LO + 6'(4 * (i % 4)), rd);
            checkByte("count or match byte", wd[7:0], rd);
        end
        // Counting up through the top value and wrapping.
        busWrite(`T1TB_OFS_CNT_LO, 8'hf0);
        busWrite(`T1TB_OFS_CNT_HI, 8'hff);
        busWrite(`T1TB_OFS_FLAG, 8'h03);
        busWrite(`T1TB_OFS_CTRL, expCtrl(1'b1, t1tb_pkg::T1TB_SRC_SYS, 1'b0, 1'b0));
        busRead(`T1TB_OFS_CNT_HI, rd);
        checkByte("count high before wrap", 8'hff, rd);
        pollFlag(0);
        checkBit("overflow flag", 1'b1, rd[0]);
        busWrite(`T1TB_OFS_CTRL, 8'h00);
        busRead(`T1TB_OFS_CNT_HI, rd);
        checkByte("count high after wrap", 8'h00, rd);
        // The interrupt needs the timer on and all three enables.
        busWrite(`T1TB_OFS_IEN, 8'h01);
        busWrite(`T1TB_OFS_CORE, 8'hc0);
        busRead(`T1TB_OFS_FLAG, rd);
        checkBit("flag held", 1'b1, rd[0]);
        checkBit("irq with timer off", 1'b0, irq);
        busWrite(`T1TB_OFS_CTRL, expCtrl(1'b1, t1tb_pkg::T1TB_SRC_SYS, 1'b0, 1'b0));
        busRead(`T1TB_OFS_FLAG, rd);
        checkBit("irq all enabled", 1'b1, irq);
        for (i = 0; i < 3; i++)
        begin
            busWrite(i == 0 ? `T1TB_OFS_IEN : `T1TB_OFS_CORE, i == 0 ? 8'h00 : (i == 1 ? 8'h80 : 8'h40));
            busRead(`T1TB_OFS_FLAG, rd);
            checkBit("irq with one enable off", 1'b0, irq);
            busWrite(`T1TB_OFS_IEN, 8'h01);
            busWrite(`T1TB_OFS_CORE, 8'hc0);
        end
        busWrite(`T1TB_OFS_FLAG, 8'h01);
        busRead(`T1TB_OFS_FLAG, rd);
        checkByte("flag cleared", 8'h00, rd);
        checkBit("irq after clear", 1'b0, irq);
        // Asleep in synchronous mode the count must stand still.
        busWrite(`T1TB_OFS_CTRL, expCtrl(1'b1, t1tb_pkg::T1TB_SRC_SYS, 1'b1, 1'b0));
        sleepIn <= 1'b1;
        busWrite(`T1TB_OFS_CNT_LO, 8'h00);
        busRead(`T1TB_OFS_CNT_LO, rd);
        checkByte("no count asleep", 8'h00, rd);
        busRead(`T1TB_OFS_STAT, rd);
        checkByte("osc runs asleep", 8'h03, rd);
        // Asleep as an asynchronous counter on the external clock, overflow wakes.
        busWrite(`T1TB_OFS_CNT_LO, 8'hf8);
        busWrite(`T1TB_OFS_CNT_HI, 8'hff);
        halfPeriod <= 4'($random(seed));
        runExt <= 1'b1;
        busWrite(`T1TB_OFS_CTRL, expCtrl(1'b1, t1tb_pkg::T1TB_SRC_PIN, 1'b1, 1'b1));
        for (k = 0; k < 3000 && wakeReq !== 1'b1; k++) @(posedge clk);
        checkBit("wake", 1'b1, wakeReq);
        runExt <= 1'b0;
        sleepIn <= 1'b0;
        busRead(`T1TB_OFS_FLAG, rd);
        checkBit("irq after wake", 1'b1, irq);
        // Capture copies the frozen count into the match pair.
        busWrite(`T1TB_OFS_CTRL, 8'h00);
        busWrite(`T1TB_OFS_FLAG, 8'h03);
        busWrite(`T1TB_OFS_CNT_LO, 8'h34);
        busWrite(`T1TB_OFS_CNT_HI, 8'h12);
        busWrite(`T1TB_OFS_CCP, 8'h05);
        capPulse <= 1'b1;
        pollFlag(1);
        capPulse <= 1'b0;
        busRead(`T1TB_OFS_MAT_LO, rd);
        checkByte("captured low", 8'h34, rd);
        busRead(`T1TB_OFS_MAT_HI, rd);
        checkByte("captured high", 8'h12, rd);
        // Compare with special event: period register, no overflow flag.
        busWrite(`T1TB_OFS_CCP, 8'h03);
        busWrite(`T1TB_OFS_MAT_LO, 8'h10);
        busWrite(`T1TB_OFS_MAT_HI, 8'h00);
        busWrite(`T1TB_OFS_CNT_HI, 8'h00);
        busWrite(`T1TB_OFS_CNT_LO, 8'h00);
        busWrite(`T1TB_OFS_FLAG, 8'h03);
        busWrite(`T1TB_OFS_CTRL, expCtrl(1'b1, t1tb_pkg::T1TB_SRC_SYS, 1'b0, 1'b0));
        pollFlag(1);
        checkBit("compare flag", 1'b1, rd[1]);
        for (i = 0; i < 12; i++)
        begin
            busRead(`T1TB_OFS_CNT_LO, rd);
            checkBit("count within period", 1'b1, rd <= 8'h12);
        end
        busRead(`T1TB_OFS_FLAG, rd);
        checkBit("no overflow on special event", 1'b0, rd[0]);
        final_report();
    end
endmodule
